// ===== uie_defines.vh
`ifndef UIE_DEFINES_VH
`define UIE_DEFINES_VH
`define UIE_A_CTRL     8'h00
`define UIE_A_BAUD     8'h04
`define UIE_A_MOD      8'h08
`define UIE_A_IRDA     8'h0c
`define UIE_A_STAT     8'h10
`define UIE_A_RXBUF    8'h14
`define UIE_A_TXBUF    8'h18
`define UIE_C_SWRST    0
`define UIE_C_PAR_EN   1
`define UIE_C_PAR_EVEN 2
`define UIE_C_TWO_STOP 3
`define UIE_C_MODE     5:4
`define UIE_C_RXEIE    6
`define UIE_C_BRKIE    7
`define UIE_C_OS16     8
`define UIE_C_IREN     9
`define UIE_C_IRTXCLK  10
`define UIE_C_IRRXPL   11
`define UIE_C_IRRXFE   12
`define UIE_M_BRS      2:0
`define UIE_M_BRF      7:4
`define UIE_I_TXPL     5:0
`define UIE_I_RXFL     13:8
`define UIE_S_RXIFG    0
`define UIE_S_TXIFG    1
`define UIE_S_FE       2
`define UIE_S_PE       3
`define UIE_S_OE       4
`define UIE_S_BRK      5
`define UIE_S_RXERR    6
`define UIE_S_IDLE     7
`define UIE_S_BUSY     8
`define UIE_CTRL_RST   16'h0001
`define UIE_BAUD_RST   16'h0010
`define UIE_MOD_RST    16'h0000
`define UIE_IRDA_RST   16'h0000
`define UIE_MODE_IDLE  2'h1
`define UIE_MODE_ADDR  2'h2
`define UIE_MODE_AUTO  2'h3
`define UIE_DATA_BITS  4'h8
`define UIE_IDLE_ONES  4'ha
`define UIE_FILT_EXTRA 9'h004
`define UIE_VOTE_SUB   5'h07
`define UIE_SUBS_LAST  5'h0f
`endif

// ===== uie_baud.v
`default_nettype none
`include "uie_defines.vh"
module uie_baud (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        ce,
	input  wire        run,
	input  wire        restart,
	input  wire        os16,
	input  wire [15:0] prescaler,
	input  wire [3:0]  first_mod,
	input  wire [2:0]  second_mod,
	output wire        bit_tick,
	output wire        sample_tick,
	output wire        x16_tick
);
	reg  [15:0] cnt;
	reg  [4:0]  sub;
	reg  [2:0]  bidx;
	reg  [7:0]  pattern;

	always @* begin
		case (second_mod)
		3'h0: pattern = 8'h00;
		3'h1: pattern = 8'h02;
		3'h2: pattern = 8'h22;
		3'h3: pattern = 8'h2a;
		3'h4: pattern = 8'haa;
		3'h5: pattern = 8'hae;
		3'h6: pattern = 8'hee;
		default: pattern = 8'hfe;
		endcase
	end

	wire        m_bit    = pattern[bidx];
	wire        bypass   = prescaler < 16'h0002;
	wire [7:0]  prod     = {4'h0, sub[3:0]} * {4'h0, first_mod};
	wire [4:0]  acc      = {1'b0, prod[3:0]} + {1'b0, first_mod};
	// spreads first_mod stretched sub-periods evenly over the sixteen
	wire        stretch  = ~bypass & ~sub[4] & (acc > 5'h0f);
	wire [15:0] sub_len  = bypass ? 16'h0001 : prescaler + {15'h0, stretch};
	wire [15:0] lf_len   = prescaler + {15'h0, m_bit};
	wire [15:0] seg_len  = os16 ? sub_len : lf_len;
	wire [16:0] cnt_nxt  = {1'b0, cnt} + 17'h00001;
	wire        seg_end  = run & (cnt_nxt >= {1'b0, seg_len});
	// the second-stage bit adds one whole sixteenth period in oversampling
	wire [4:0]  sub_last = `UIE_SUBS_LAST + {4'h0, m_bit};
	wire        os_end   = seg_end & (sub == sub_last);
	wire [15:0] half     = {1'b0, prescaler[15:1]};
	wire        lf_samp  = (cnt == half - 16'h0001) | (cnt == half) | (cnt == half + 16'h0001);
	wire        os_samp  = (sub == `UIE_VOTE_SUB - 5'h01) | (sub == `UIE_VOTE_SUB) |
	                       (sub == `UIE_VOTE_SUB + 5'h01);

	assign x16_tick    = os16 & seg_end;
	assign bit_tick    = os16 ? os_end : seg_end;
	assign sample_tick = run & (os16 ? (seg_end & os_samp) : lf_samp);

	always @(posedge clk_sys) begin
		if (rst) begin
			cnt  <= 16'h0000;
			sub  <= 5'h00;
			bidx <= 3'h0;
		end else if (ce) begin
			// unclocked while idle; pattern restarts on every start bit
			if (~run | restart) begin
				cnt  <= 16'h0000;
				sub  <= 5'h00;
				bidx <= 3'h0;
			end else if (seg_end) begin
				cnt <= 16'h0000;
				if (~os16 | os_end) begin
					sub  <= 5'h00;
					bidx <= bidx + 3'h1;
				end else begin
					sub <= sub + 5'h01;
				end
			end else begin
				cnt <= cnt_nxt[15:0];
			end
		end
	end
endmodule
`default_nettype wire

// ===== uie_uart.v
// Our own choices: the register addresses and the address-and-strobe port.
`default_nettype none
`include "uie_defines.vh"
module uie_uart (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        ce,
	input  wire [7:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	input  wire        serial_rx_input,
	output reg         serial_tx_output
);
	localparam R_IDLE    = 2'h0;
	localparam R_START   = 2'h1;
	localparam R_DATA    = 2'h2;
	localparam R_IDLECHK = 2'h3;
	localparam T_IDLE    = 1'b0;
	localparam T_SEND    = 1'b1;

	reg  [15:0] ctrl;
	reg  [15:0] baud_prescaler;
	reg  [15:0] mod_reg;
	reg  [15:0] irda_reg;

	wire        soft_reset_bit  = ctrl[`UIE_C_SWRST];
	wire        par_en          = ctrl[`UIE_C_PAR_EN];
	wire        par_even        = ctrl[`UIE_C_PAR_EVEN];
	wire        two_stop        = ctrl[`UIE_C_TWO_STOP];
	wire [1:0]  serial_mode_field = ctrl[`UIE_C_MODE];
	wire        rx_error_char_enable = ctrl[`UIE_C_RXEIE];
	wire        break_irq_enable = ctrl[`UIE_C_BRKIE];
	wire        oversampling_select = ctrl[`UIE_C_OS16];
	wire        irda_enable     = ctrl[`UIE_C_IREN];
	wire        ir_tx_pulse_clock_select = ctrl[`UIE_C_IRTXCLK];
	wire        ir_rx_polarity  = ctrl[`UIE_C_IRRXPL];
	wire        ir_rx_filter_enable = ctrl[`UIE_C_IRRXFE];
	wire [2:0]  second_stage_modulation = mod_reg[`UIE_M_BRS];
	wire [3:0]  first_stage_modulation = mod_reg[`UIE_M_BRF];
	wire [5:0]  ir_tx_pulse_length = irda_reg[`UIE_I_TXPL];
	wire [5:0]  ir_rx_filter_length = irda_reg[`UIE_I_RXFL];
	wire        addr_mode       = serial_mode_field == `UIE_MODE_ADDR;
	wire        hold            = rst | soft_reset_bit;

	// frame layout: data 0..7, then address bit, parity bit, stop bit(s)
	wire [3:0]  par_pos  = `UIE_DATA_BITS + {3'h0, addr_mode};
	wire [3:0]  stop_pos = par_pos + {3'h0, par_en};
	wire [3:0]  n_bits   = stop_pos + 4'h1 + {3'h0, two_stop};
	wire [11:0] len_mask = (12'h001 << n_bits) - 12'h001;

	wire        wr_ctrl  = reg_wr & (reg_addr == `UIE_A_CTRL);
	wire        wr_stat  = reg_wr & (reg_addr == `UIE_A_STAT);
	wire        wr_tx    = reg_wr & (reg_addr == `UIE_A_TXBUF) & ~soft_reset_bit;
	wire        rd_stat  = reg_rd & (reg_addr == `UIE_A_STAT);
	wire        rd_rxbuf = reg_rd & (reg_addr == `UIE_A_RXBUF);
	wire [15:0] clr_mask = wr_stat ? reg_wdata : 16'h0000;

	// receive side state
	reg  [1:0]  rx_state;
	reg  [3:0]  rx_cnt;
	reg  [11:0] rx_frame;
	reg  [2:0]  samp;
	reg  [3:0]  ones;
	reg         rx_prev;
	reg  [7:0]  filt_cnt;
	reg         ir_low;
	reg  [7:0]  rx_buffer;
	reg         rx_irq_flag;
	reg         framing_error_flag;
	reg         parity_error_flag;
	reg         overrun_flag;
	reg         break_flag;
	reg         rx_error_summary;
	reg         idle_detected_flag;
	reg         ovr_since_stat;
	// transmit side state, then the status word
	reg         t_state;
	reg  [11:0] tsh;
	reg  [3:0]  t_left;
	reg         tx_bit;
	reg         bit_new;
	reg         tx_full;
	reg  [7:0]  tx_buffer;
	reg         tx_irq_flag;
	reg         ir_pulse;
	reg  [7:0]  ir_half;
	reg  [15:0] stat_word;

	wire        rx_tick;
	wire        rx_samp;
	wire        tx_tick;
	wire        tx_x16;

	// IrDA receive decode; a qualified pulse holds the line low to the bit end
	wire        ir_active = ir_rx_polarity ? ~serial_rx_input : serial_rx_input;
	wire [8:0]  ir_halves = {filt_cnt, 1'b0} + 9'h002;
	wire [8:0]  ir_thresh = {3'h0, ir_rx_filter_length} + `UIE_FILT_EXTRA;
	wire        ir_qual   = ir_active & (~ir_rx_filter_enable | (ir_halves > ir_thresh));
	wire        rx_line   = irda_enable ? ~ir_low : serial_rx_input;
	wire        fall      = rx_prev & ~rx_line;

	// the third sample may land on the bit-end cycle, so vote on it directly
	wire [2:0]  samp_now  = rx_samp ? {samp[1:0], rx_line} : samp;
	wire        vote      = (samp_now[0] & samp_now[1]) | (samp_now[0] & samp_now[2]) |
	                        (samp_now[1] & samp_now[2]);
	wire [11:0] frame_now = rx_frame | ({11'h000, vote} << rx_cnt);
	wire        last_bit  = rx_cnt == (n_bits - 4'h1);
	wire        char_done = (rx_state == R_DATA) & rx_tick & last_bit;
	wire        stop_ok   = frame_now[stop_pos] & (~two_stop | frame_now[stop_pos + 4'h1]);
	wire        par_x     = (^frame_now[7:0]) ^ (addr_mode & frame_now[8]) ^ frame_now[par_pos];
	wire        fe_set    = char_done & ~stop_ok;
	wire        pe_set    = char_done & par_en & (par_x ^ ~par_even);
	wire        brk_set   = char_done & (serial_mode_field != `UIE_MODE_AUTO) &
	                        ((frame_now & len_mask) == 12'h000);
	wire        store     = char_done & (~(fe_set | pe_set) | rx_error_char_enable);
	wire        oe_set    = store & rx_irq_flag;
	wire        idle_set  = (rx_state == R_IDLECHK) & ~fall & rx_tick & vote &
	                        (ones == `UIE_IDLE_ONES - 4'h1);
	wire        rx_run    = rx_state != R_IDLE;
	wire        rx_restart = (rx_state == R_IDLECHK) & fall;

	// transmit framing; spare high bits past the frame are never sent
	wire [7:0]  td        = tx_buffer;
	wire        tpar      = (^td) ^ ~par_even;
	wire [11:0] t_frame   = addr_mode ? (par_en ? {2'h3, tpar, 1'b0, td} : {3'h7, 1'b0, td}) :
	                                    (par_en ? {3'h7, tpar, td} : {4'hf, td});
	wire        tx_load   = tx_tick & tx_full & ((t_state == T_IDLE) | (t_left == 4'h0));
	wire        tx_run    = tx_full | (t_state == T_SEND);
	wire        next_tx_full = wr_tx | (tx_full & ~tx_load);
	wire [7:0]  pl_halves = {2'h0, ir_tx_pulse_length} + 8'h01;
	wire [7:0]  next_half = ir_half + 8'h02;
	// with the source clock picked, one half-step per cycle assumes prescaler >= 5
	wire        ir_step   = ir_tx_pulse_clock_select ? tx_x16 : 1'b1;

	uie_baud u_rx_baud (
		.clk_sys     (clk_sys),
		.rst         (hold),
		.ce          (ce),
		.run         (rx_run),
		.restart     (rx_restart),
		.os16        (oversampling_select),
		.prescaler   (baud_prescaler),
		.first_mod   (first_stage_modulation),
		.second_mod  (second_stage_modulation),
		.bit_tick    (rx_tick),
		.sample_tick (rx_samp),
		.x16_tick    ()
	);

	uie_baud u_tx_baud (
		.clk_sys     (clk_sys),
		.rst         (hold),
		.ce          (ce),
		.run         (tx_run),
		.restart     (tx_load),
		.os16        (oversampling_select),
		.prescaler   (baud_prescaler),
		.first_mod   (first_stage_modulation),
		.second_mod  (second_stage_modulation),
		.bit_tick    (tx_tick),
		.sample_tick (),
		.x16_tick    (tx_x16)
	);

	always @(posedge clk_sys) begin
		if (rst) begin
			ctrl           <= `UIE_CTRL_RST;
			baud_prescaler <= `UIE_BAUD_RST;
			mod_reg        <= `UIE_MOD_RST;
			irda_reg       <= `UIE_IRDA_RST;
		end else if (ce & reg_wr) begin
			if (reg_addr == `UIE_A_CTRL) begin
				ctrl <= reg_wdata;
			end else if (reg_addr == `UIE_A_BAUD) begin
				baud_prescaler <= reg_wdata;
			end else if (reg_addr == `UIE_A_MOD) begin
				mod_reg <= reg_wdata;
			end else if (reg_addr == `UIE_A_IRDA) begin
				irda_reg <= reg_wdata;
			end
		end
	end

	always @(posedge clk_sys) begin
		if (hold | ~irda_enable) begin
			filt_cnt <= 8'h00;
			ir_low   <= 1'b0;
		end else if (ce) begin
			filt_cnt <= ir_active ? ((filt_cnt == 8'hff) ? filt_cnt : filt_cnt + 8'h01) : 8'h00;
			// a pulse straddling a bit end would also mark the next bit
			ir_low   <= ir_qual | (ir_low & ~rx_tick);
		end
	end

	always @(posedge clk_sys) begin
		if (hold) begin
			rx_state <= R_IDLE;
			rx_cnt   <= 4'h0;
			rx_frame <= 12'h000;
			samp     <= 3'h7;
			ones     <= 4'h0;
			rx_prev  <= 1'b1;
		end else if (ce) begin
			rx_prev <= rx_line;
			if (rx_samp) begin
				samp <= samp_now;
			end
			case (rx_state)
			R_IDLE: begin
				if (fall) begin
					rx_state <= R_START;
				end
			end
			R_START: begin
				if (rx_tick) begin
					rx_cnt   <= 4'h0;
					rx_frame <= 12'h000;
					rx_state <= vote ? R_IDLE : R_DATA;
				end
			end
			R_DATA: begin
				if (rx_tick) begin
					rx_frame <= frame_now;
					rx_cnt   <= rx_cnt + 4'h1;
					if (last_bit) begin
						ones     <= 4'h0;
						rx_state <= (serial_mode_field == `UIE_MODE_IDLE) ? R_IDLECHK : R_IDLE;
					end
				end
			end
			default: begin
				if (fall) begin
					rx_state <= R_START;
				end else if (rx_tick) begin
					if (~vote) begin
						ones <= 4'h0;
					end else if (idle_set) begin
						rx_state <= R_IDLE;
					end else begin
						ones <= ones + 4'h1;
					end
				end
			end
			endcase
		end
	end

	always @(posedge clk_sys) begin
		if (hold) begin
			rx_buffer          <= 8'h00;
			rx_irq_flag        <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag  <= 1'b0;
			overrun_flag       <= 1'b0;
			break_flag         <= 1'b0;
			rx_error_summary   <= 1'b0;
			idle_detected_flag <= 1'b0;
			ovr_since_stat     <= 1'b0;
		end else if (ce) begin
			if (store) begin
				rx_buffer <= frame_now[7:0];
			end
			// in every flag below a hardware set outranks any clear
			rx_irq_flag        <= store | (brk_set & break_irq_enable) | (rx_irq_flag & ~rd_rxbuf);
			framing_error_flag <= fe_set | (framing_error_flag & ~(rd_rxbuf | clr_mask[`UIE_S_FE]));
			parity_error_flag  <= pe_set | (parity_error_flag & ~(rd_rxbuf | clr_mask[`UIE_S_PE]));
			break_flag         <= brk_set | (break_flag & ~(rd_rxbuf | clr_mask[`UIE_S_BRK]));
			rx_error_summary   <= fe_set | pe_set | oe_set |
			                      (rx_error_summary & ~(rd_rxbuf | clr_mask[`UIE_S_RXERR]));
			// an overwrite after the last status read keeps overrun alive
			ovr_since_stat     <= oe_set | (ovr_since_stat & ~rd_stat);
			overrun_flag       <= oe_set | (overrun_flag & ~(rd_rxbuf & ~ovr_since_stat));
			idle_detected_flag <= idle_set | (idle_detected_flag & ~(rd_rxbuf | clr_mask[`UIE_S_IDLE]));
		end
	end

	always @(posedge clk_sys) begin
		if (hold) begin
			t_state     <= T_IDLE;
			tsh         <= 12'hfff;
			t_left      <= 4'h0;
			tx_bit      <= 1'b1;
			bit_new     <= 1'b0;
			tx_full     <= 1'b0;
			tx_buffer   <= 8'h00;
			tx_irq_flag <= 1'b1;
		end else if (ce) begin
			bit_new     <= 1'b0;
			tx_full     <= next_tx_full;
			tx_irq_flag <= ~next_tx_full;
			if (wr_tx) begin
				tx_buffer <= reg_wdata[7:0];
			end
			if (tx_load) begin
				tsh     <= t_frame;
				t_left  <= n_bits;
				tx_bit  <= 1'b0;
				bit_new <= 1'b1;
				t_state <= T_SEND;
			end else if (tx_tick & (t_state == T_SEND)) begin
				bit_new <= 1'b1;
				if (t_left != 4'h0) begin
					tx_bit <= tsh[0];
					tsh    <= {1'b1, tsh[11:1]};
					t_left <= t_left - 4'h1;
				end else begin
					tx_bit  <= 1'b1;
					t_state <= T_IDLE;
				end
			end
		end
	end

	always @(posedge clk_sys) begin
		if (hold) begin
			ir_pulse         <= 1'b0;
			ir_half          <= 8'h00;
			serial_tx_output <= 1'b1;
		end else if (ce) begin
			if (bit_new) begin
				ir_pulse <= ~tx_bit;
				ir_half  <= 8'h00;
			end else if (ir_pulse & ir_step) begin
				ir_half <= next_half;
				if (next_half >= pl_halves) begin
					ir_pulse <= 1'b0;
				end
			end
			serial_tx_output <= irda_enable ? ir_pulse : tx_bit;
		end
	end

	always @* begin
		stat_word = 16'h0000;
		stat_word[`UIE_S_RXIFG] = rx_irq_flag;
		stat_word[`UIE_S_TXIFG] = tx_irq_flag;
		stat_word[`UIE_S_FE]    = framing_error_flag;
		stat_word[`UIE_S_PE]    = parity_error_flag;
		stat_word[`UIE_S_OE]    = overrun_flag;
		stat_word[`UIE_S_BRK]   = break_flag;
		stat_word[`UIE_S_RXERR] = rx_error_summary;
		stat_word[`UIE_S_IDLE]  = idle_detected_flag;
		stat_word[`UIE_S_BUSY]  = rx_run | tx_run;
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (ce) begin
			if (~reg_rd) begin
				reg_rdata <= 16'h0000;
			end else if (reg_addr == `UIE_A_CTRL) begin
				reg_rdata <= ctrl;
			end else if (reg_addr == `UIE_A_BAUD) begin
				reg_rdata <= baud_prescaler;
			end else if (reg_addr == `UIE_A_MOD) begin
				reg_rdata <= mod_reg;
			end else if (reg_addr == `UIE_A_IRDA) begin
				reg_rdata <= irda_reg;
			end else if (reg_addr == `UIE_A_STAT) begin
				reg_rdata <= stat_word;
			end else if (reg_addr == `UIE_A_RXBUF) begin
				reg_rdata <= {8'h00, rx_buffer};
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end
endmodule
`default_nettype wire

// ===== uie_uart_asserts.sv
`default_nettype none
`include "uie_defines.vh"
module uie_uart_asserts (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        serial_rx_input,
	input wire logic        serial_tx_output
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ctrl, baud, mods, irda, unit;
	logic [7:0]  seg;
	logic        tx_q, sw, ir;
	assign sw = ctrl[`UIE_C_SWRST];
	assign ir = ctrl[`UIE_C_IREN];
	assign unit = ctrl[`UIE_C_OS16] ? 16'h0010 : baud;
	// shadow of the config so the line checks know the programmed rates
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl <= `UIE_CTRL_RST;
			baud <= `UIE_BAUD_RST;
			mods <= `UIE_MOD_RST;
			irda <= `UIE_IRDA_RST;
		end else if (ce && reg_wr) begin
			if (reg_addr == `UIE_A_CTRL) ctrl <= reg_wdata;
			if (reg_addr == `UIE_A_BAUD) baud <= reg_wdata;
			if (reg_addr == `UIE_A_MOD) mods <= reg_wdata;
			if (reg_addr == `UIE_A_IRDA) irda <= reg_wdata;
		end
	end
	// length of the level the line held before its latest change; saturates so idle is ignored
	always_ff @(posedge clk_sys) begin
		tx_q <= serial_tx_output;
		if (rst) seg <= 8'hff;
		else if (serial_tx_output != tx_q) seg <= 8'h01;
		else if (seg != 8'hff) seg <= seg + 8'h01;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_sw_idle;
		sw && $past(sw) && !ir |=> serial_tx_output;
	endproperty
	a_sw_idle: assert property (p_sw_idle) else $error("tx busy in soft reset");
	property p_sw_stat;
		ce && reg_rd && reg_addr == `UIE_A_STAT && sw && $past(sw) |=> reg_rdata[8:0] == 9'h002;
	endproperty
	a_sw_stat: assert property (p_sw_stat) else $error("status not clean in soft reset");
	property p_tx_start;
		ce && reg_wr && reg_addr == `UIE_A_TXBUF && !sw && !ir |-> ##[1:1000] !serial_tx_output;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("tx write sent nothing");
	property p_bit_len;
		$rose(serial_tx_output) && !ir && mods[2:0] == 3'h0 && seg != 8'hff && unit != 16'h0
			&& (!ctrl[`UIE_C_OS16] || baud <= 16'h0001) |-> ({8'h00, seg} % unit) == 16'h0000;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("tx bit length wrong");
	property p_ir_pulse;
		$fell(serial_tx_output) && ir && !ctrl[`UIE_C_IRTXCLK] && seg < 8'h28
			|-> seg == (({2'h0, irda[5:0]} + 8'h02) >> 1);
	endproperty
	a_ir_pulse: assert property (p_ir_pulse) else $error("ir pulse length wrong");
	property p_rd_quiet;
		ce && !reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read");
	property p_unmapped;
		ce && reg_rd && reg_addr > `UIE_A_TXBUF |=> reg_rdata == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rx_upper;
		ce && reg_rd && reg_addr == `UIE_A_RXBUF |=> reg_rdata[15:8] == 8'h00;
	endproperty
	a_rx_upper: assert property (p_rx_upper) else $error("rx buffer upper byte set");
	property p_ctrl_rb;
		ce && reg_rd && reg_addr == `UIE_A_CTRL |=> reg_rdata[12:0] == ctrl[12:0];
	endproperty
	a_ctrl_rb: assert property (p_ctrl_rb) else $error("ctrl readback wrong");
endmodule
bind uie_uart uie_uart_asserts u_chk (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .serial_rx_input, .serial_tx_output);
`default_nettype wire

// ===== uie_peer.sv
`default_nettype none
module uie_peer (
	input  wire logic        clk_sys,
	input  wire logic        tx_line,
	input  wire logic [15:0] bit_len,
	output var  logic        rx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q [$];
	logic [7:0] sh;
	initial rx_line = 1'b1;
	// mid-bit sampling at a fixed rate tolerates the few cycles of drift modulation adds
	always begin
		@(negedge tx_line);
		repeat (bit_len / 2) @(posedge clk_sys);
		for (int k = 0; k < 8; k++) begin
			repeat (bit_len) @(posedge clk_sys);
			sh[k] = tx_line;
		end
		repeat (bit_len) @(posedge clk_sys);
		rx_q.push_back(sh);
	end
	// without parity the eleventh slot is plain idle
	task automatic send(input logic [7:0] d, input logic pen, pb, stp);
		logic [10:0] f;
		f = pen ? {stp, pb, d, 1'b0} : {1'b1, stp, d, 1'b0};
		for (int k = 0; k < 11; k++) begin
			rx_line <= f[k];
			repeat (bit_len) @(posedge clk_sys);
		end
		rx_line <= 1'b1;
		@(posedge clk_sys);
	endtask
	task automatic glitch(input int n);
		rx_line <= 1'b0;
		repeat (n) @(posedge clk_sys);
		rx_line <= 1'b1;
		@(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ===== uie_uart_bench.sv
`default_nettype none
`include "uie_defines.vh"
module uie_uart_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, rst, ce, reg_wr, reg_rd, tx_q;
	logic [7:0]  reg_addr, d;
	logic [15:0] reg_wdata, bit_len, st, v;
	wire  [15:0] reg_rdata;
	wire         rxl, txl;
	int          error_cnt, cmp_count, seed, i, pulses, p0;
	logic [7:0]  ra [5] = '{`UIE_A_CTRL, `UIE_A_BAUD, `UIE_A_MOD, `UIE_A_IRDA, 8'h1c};
	logic [15:0] rv [5] = '{`UIE_CTRL_RST, `UIE_BAUD_RST, `UIE_MOD_RST, `UIE_IRDA_RST, 16'h0000};
	uie_uart uut (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.serial_rx_input(rxl), .serial_tx_output(txl));
	uie_peer peer (.clk_sys, .tx_line(txl), .bit_len, .rx_line(rxl));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial pulses = 0;
	always @(posedge clk_sys) begin
		tx_q <= txl;
		if (txl === 1'b1 && tx_q === 1'b0) pulses <= pulses + 1;
	end
	function automatic logic [15:0] pulses_for(input logic [7:0] x);
		pulses_for = 16'h0001;
		for (int k = 0; k < 8; k++) pulses_for = pulses_for + {15'h0000, ~x[k]};
	endfunction
	task automatic chk(input logic [15:0] g, e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] q);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		// read data stand for one cycle only; take them mid-cycle, clear of the launching edge
		@(negedge clk_sys);
		q = reg_rdata;
		@(posedge clk_sys);
	endtask
	task automatic wait_tx(input int n);
		for (int k = 0; k < 3000; k++) begin
			rd(`UIE_A_STAT, st);
			if (st[`UIE_S_TXIFG] === 1'b1 && peer.rx_q.size() >= n) return;
		end
		error_cnt++;
		finish_test();
	endtask
	task automatic xfer(input logic [15:0] c, b, m, bl);
		logic [7:0] x, y;
		x = 8'($random(seed));
		y = 8'($random(seed));
		bit_len <= bl;
		wr(`UIE_A_BAUD, b);
		wr(`UIE_A_MOD, m);
		wr(`UIE_A_CTRL, c);
		wr(`UIE_A_TXBUF, {8'h00, x});
		wait_tx(0);
		wr(`UIE_A_TXBUF, {8'h00, y});
		wait_tx(2);
		chk({8'h00, peer.rx_q[0]}, {8'h00, x});
		chk({8'h00, peer.rx_q[1]}, {8'h00, y});
		peer.rx_q = {};
		peer.send(y, 1'b0, 1'b0, 1'b1);
		rd(`UIE_A_RXBUF, v);
		chk(v, {8'h00, y});
	endtask
	task automatic rx_err(input logic [15:0] c, input logic [7:0] dd, input logic pen, pb, stp,
		input logic [15:0] e);
		wr(`UIE_A_CTRL, c);
		peer.send(dd, pen, pb, stp);
		rd(`UIE_A_STAT, st);
		chk(st & 16'h007d, e);
		rd(`UIE_A_RXBUF, v);
	endtask
	initial begin
		seed = 32'h966a51b6;
		error_cnt = 0;
		cmp_count = 0;
		ce = 1'b1;
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		bit_len = 16'h0010;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`UIE_A_STAT, st);
		chk(st & 16'h01ff, 16'h0002);
		for (i = 0; i < 5; i++) begin
			rd(ra[i], v);
			chk(v, rv[i]);
		end
		for (i = 0; i < 8; i++) xfer(16'h0000, 16'h0010, i[15:0], 16'h0010);
		xfer(16'h0100, 16'h0001, 16'h0070, 16'h0010);
		xfer(16'h0100, 16'h0002, 16'h0040, 16'h0024);
		wr(`UIE_A_BAUD, 16'h0010);
		wr(`UIE_A_MOD, 16'h0000);
		bit_len <= 16'h0010;
		d = 8'($random(seed)) | 8'h01;
		rx_err(16'h0000, d, 1'b0, 1'b0, 1'b0, 16'h0044);
		rx_err(16'h0040, d, 1'b0, 1'b0, 1'b0, 16'h0045);
		rx_err(16'h0048, d, 1'b1, 1'b1, 1'b0, 16'h0045);
		rx_err(16'h0046, d, 1'b1, ~^d, 1'b1, 16'h0049);
		rx_err(16'h0046, d, 1'b1, ^d, 1'b1, 16'h0001);
		rx_err(16'h0080, 8'h00, 1'b0, 1'b0, 1'b0, 16'h0065);
		peer.send(d, 1'b0, 1'b0, 1'b0);
		wr(`UIE_A_STAT, 16'h0044);
		rd(`UIE_A_STAT, st);
		chk(st & 16'h0044, 16'h0000);
		peer.send(d, 1'b0, 1'b0, 1'b1);
		rx_err(16'h0000, ~d, 1'b0, 1'b0, 1'b1, 16'h0051);
		chk(v, {8'h00, ~d});
		rd(`UIE_A_STAT, st);
		chk(st & 16'h0051, 16'h0000);
		peer.glitch(2);
		repeat (400) @(posedge clk_sys);
		rd(`UIE_A_STAT, st);
		chk(st & 16'h0101, 16'h0000);
		rx_err(16'h0010, d, 1'b0, 1'b0, 1'b1, 16'h0001);
		repeat (240) @(posedge clk_sys);
		rd(`UIE_A_STAT, st);
		chk(st & 16'h0180, 16'h0080);
		wr(`UIE_A_IRDA, 16'h0005);
		rx_err(16'h0a00, d, 1'b0, 1'b0, 1'b1, 16'h0001);
		chk(v, {8'h00, d});
		wr(`UIE_A_IRDA, 16'h2805);
		// isolated lows only, so no run of zero bits can outlast the filter
		rx_err(16'h1a00, 8'h55, 1'b0, 1'b0, 1'b1, 16'h0000);
		p0 = pulses;
		wr(`UIE_A_TXBUF, {8'h00, d});
		repeat (220) @(posedge clk_sys);
		chk(16'(pulses - p0), pulses_for(d));
		finish_test();
	end
endmodule
`default_nettype wire
